/* File: fmsp_pkg.sv */
/*
 * Package for the four-mode serial port: register offsets, control/status
 * field positions, reset values, mode encodings and bit-timing counts.
 * Assumes a 25 MHz APB clock that stands in for the oscillator.
 */
`default_nettype none
package fmsp_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] FMSP_OFF_CTRL = 8'h00;
	localparam logic [7:0] FMSP_OFF_DATA = 8'h04;
	localparam logic [7:0] FMSP_OFF_AUX = 8'h08;
	// Control/status field positions.
	localparam int FMSP_BIT_RXDONE = 0;
	localparam int FMSP_BIT_TXDONE = 1;
	localparam int FMSP_BIT_RX9 = 2;
	localparam int FMSP_BIT_TX9 = 3;
	localparam int FMSP_BIT_RXEN = 4;
	localparam int FMSP_BIT_MPF = 5;
	localparam int FMSP_BIT_MODELO = 6;
	localparam int FMSP_BIT_MODEHI = 7;
	// Auxiliary register field positions.
	localparam int FMSP_BIT_DOUBLER = 0;
	localparam int FMSP_BIT_TXSRC = 1;
	localparam int FMSP_BIT_RXSRC = 2;
	localparam int FMSP_BIT_TXBUSY = 3;
	localparam int FMSP_BIT_RXBUSY = 4;
	// Reset values.
	localparam logic [7:0] FMSP_CTRL_RST = 8'h00;
	localparam logic [2:0] FMSP_AUX_RST = 3'h0;
	// Timing counts in oscillator cycles.
	localparam int FMSP_M0_DIV = 12;
	localparam int FMSP_M2_DIV = 64;
	localparam int FMSP_T1_DIV = 16;
	localparam int FMSP_T2_DIV = 16;
	localparam int FMSP_RX_SAMPLES = 16;
	// Modes of the port.
	typedef enum logic [1:0] {
		FMSP_MODE_SHIFT = 2'b00,
		FMSP_MODE_UART8 = 2'b01,
		FMSP_MODE_UART9F = 2'b10,
		FMSP_MODE_UART9V = 2'b11
	} fmsp_mode_type;
	// APB request as a carrier.
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} fmsp_apb_req_type;
endpackage
`default_nettype wire

/* File: fmsp_serial_port.sv */
/*
 * Four-mode serial port with APB registers: mode 0 shift register driven
 * by this block, modes 1 to 3 asynchronous frames, with a ninth bit in modes 2 and 3.
 * Assumes timer overflow pulses arrive as one-cycle pulses on pclk and that
 * the serial input pin is asynchronous to pclk.
 * Changing the mode while a frame is in flight is not supported: the bit
 * counters are sized by the mode, so software should wait for both busy
 * bits in the auxiliary register to clear first.
 * The register bus never waits, so a read returns the state before the edge.
 */
// Our own choices: the address map and the APB interface to the registers.
// Contract
// R1 - Transmit and receive run independently, simultaneously.
// R2 - Receiver accepts new byte while old unread.
// R3 - One data address: write transmit, read receive.
// R4 - Mode 0 shifts eight bits, clock osc/12.
// R5 - Mode 1 ten-bit frame, stop into ninth.
// R6 - Modes 2,3 eleven bits, ninth stored, stop ignored.
// R7 - Transmitted ninth bit comes from software field.
// R8 - Mode 2 rate osc/32 or osc/64.
// R9 - Mode 3 equals mode 2, timer rate.
// R10 - Only a data write starts transmission.
// R11 - Mode 0 receive when enabled and done clear.
// R12 - Modes 1-3 receive on start bit if enabled.
// R13 - Multiproc filter: done only when ninth bit one.
// R14 - Master sends addresses ninth one, data zero.
// R15 - Mode 1 filter: done needs valid stop.
// R16 - Multiproc filter ignored in mode 0.
// R17 - Control register holds mode, enables, ninths, flags.
// R18 - Transmit done at bit eight or stop start.
// R19 - Receive done at bit eight or mid stop.
// R20 - Mode 2 osc/64 doubler zero, else osc/32.
// R21 - Timer 1 rate times doubler over 32.
// R22 - Source bits select timer 2 per direction.
// R23 - Timer 2 rate over sixteen.
// R24 - Software clears flags; set wins over clear.
// R25 - Overrun keeps old byte, drops new.
`timescale 1ns/1ps
`default_nettype none
module fmsp_serial_port
	import fmsp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer1_ovf,
	input wire logic timer2_ovf,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic serial_aux_out
);
	// Register state, bus decode and flag events shared by the processes below.
	fmsp_apb_req_type req;
	logic [7:0] ctrl_r;
	logic [2:0] aux_r;
	logic [7:0] rx_hold_r;
	logic rx_s1_r, rx_s2_r;
	logic wr_ctrl, wr_data, wr_aux, acc;
	fmsp_mode_type mode;
	logic tx_done_set, rx_done_set, rx9_set_val, rx9_set;

	// Bundle the bus inputs once so every decoder reads the same carrier.
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign mode = fmsp_mode_type'(ctrl_r[FMSP_BIT_MODEHI:FMSP_BIT_MODELO]);
	assign acc = req.sel && req.enable;
	assign wr_ctrl = acc && req.write && req.addr == FMSP_OFF_CTRL;
	assign wr_data = acc && req.write && req.addr == FMSP_OFF_DATA;
	assign wr_aux = acc && req.write && req.addr == FMSP_OFF_AUX;
	// Every access completes in its first access cycle; no wait states.
	assign pready = 1'b1;
	// Unmapped addresses answer with an error and change nothing.
	assign pslverr = acc && req.addr != FMSP_OFF_CTRL && req.addr != FMSP_OFF_DATA
		&& req.addr != FMSP_OFF_AUX;

	// Two-flop synchroniser on the serial input pin.
	// Only the second stage is read, so a metastable first stage never reaches
	// the receiver's start detector.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end else begin
			rx_s1_r <= serial_data_in;
			rx_s2_r <= rx_s1_r;
		end
	end

	// Tick of (n)x divider; mode 0 rate tick and mode 2 sixteenth-bit tick.
	logic [3:0] m0_cnt_r;
	logic [1:0] m2_cnt_r;
	logic m0_tick, m2_tick;
	// A new mode 0 transfer restarts the divider so its first bit gets a full clock.
	logic m0_restart;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m0_cnt_r <= 4'h0;
			m2_cnt_r <= 2'h0;
		end else begin
			m0_cnt_r <= (m0_tick || m0_restart) ? 4'h0 : m0_cnt_r + 4'h1;
			m2_cnt_r <= m2_cnt_r + 2'h1;
		end
	end
	assign m0_tick = m0_cnt_r == 4'(FMSP_M0_DIV - 1); // R4
	// Mode 2 sixteenth-bit ticks: every 2 cycles doubled, else every 4.
	// The divider free-runs, so the first bit of a frame may be up to 3 cycles short.
	assign m2_tick = aux_r[FMSP_BIT_DOUBLER] ? m2_cnt_r[0] : (m2_cnt_r == 2'h3); // R8 R20

	// Timer 1 path: doubler gives 1/16, else 1/32; prescale first halves.
	// The halver keeps its phase across frames; a frame may start on either half,
	// which shifts its sub-ticks by one overflow at most.
	logic t1_half_r;
	logic t1_tick;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t1_half_r <= 1'b0;
		else if (timer1_ovf)
			t1_half_r <= ~t1_half_r;
	end
	assign t1_tick = timer1_ovf && (aux_r[FMSP_BIT_DOUBLER] || t1_half_r); // R21

	// Sixteenth-bit tick per direction; timer 2 overflow used straight, 16 per bit.
	// Mode 0 ignores these ticks entirely; it runs from the fixed divider.
	function automatic logic pick_tick(input fmsp_mode_type m, input logic src2,
		input logic t1, input logic t2, input logic m2);
		if (m == FMSP_MODE_UART9F)
			pick_tick = m2; // R9
		else
			pick_tick = src2 ? t2 : t1; // R22 R23
	endfunction
	logic tx_tick16, rx_tick16;
	assign tx_tick16 = pick_tick(mode, aux_r[FMSP_BIT_TXSRC], t1_tick, timer2_ovf, m2_tick);
	assign rx_tick16 = pick_tick(mode, aux_r[FMSP_BIT_RXSRC], t1_tick, timer2_ovf, m2_tick);

	// Transmitter. Mode 0 shifts on the mode 0 tick; others on 16 sub-ticks.
	// A data write always restarts the frame, even one in flight, so software
	// should wait for the done flag before writing again.
	// Shifted-out positions fill with ones, which also leaves the line at mark.
	logic [10:0] tx_sh_r;
	logic [3:0] tx_bits_r, tx_sub_r;
	logic tx_busy_r, tx_out_r, tx_sclk_r;
	logic [3:0] tx_nbits;
	assign tx_nbits = (mode == FMSP_MODE_SHIFT) ? 4'd8 :
		(mode == FMSP_MODE_UART8) ? 4'd10 : 4'd11; // R5 R6
	assign tx_done_set = tx_busy_r && ((mode == FMSP_MODE_SHIFT) ?
		(m0_tick && tx_bits_r == 4'd7) :
		(tx_tick16 && tx_sub_r == 4'hF && tx_bits_r == tx_nbits - 4'd2)); // R18
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh_r <= 11'h7FF;
			tx_bits_r <= 4'h0;
			tx_sub_r <= 4'h0;
			tx_busy_r <= 1'b0;
			tx_out_r <= 1'b1;
		end else if (wr_data) begin // R10
			tx_busy_r <= 1'b1;
			tx_bits_r <= 4'h0;
			tx_sub_r <= 4'h0;
			if (mode == FMSP_MODE_SHIFT) begin
				tx_sh_r <= {3'h7, req.wdata[7:0]}; // R4
				tx_out_r <= req.wdata[0];
			end else begin
				// Start, eight data LSB first, ninth from software in modes 2 and 3, stop.
				tx_sh_r <= (mode == FMSP_MODE_UART8) ? {2'h3, req.wdata[7:0], 1'b0} :
					{1'b1, ctrl_r[FMSP_BIT_TX9], req.wdata[7:0], 1'b0}; // R5 R6 R7
				tx_out_r <= 1'b0;
			end
		end else if (tx_busy_r) begin
			if (mode == FMSP_MODE_SHIFT) begin
				if (m0_tick) begin
					tx_sh_r <= {1'b1, tx_sh_r[10:1]};
					tx_out_r <= tx_sh_r[1];
					tx_bits_r <= tx_bits_r + 4'd1;
					if (tx_bits_r == 4'd7)
						tx_busy_r <= 1'b0;
				end
			end else if (tx_tick16) begin
				tx_sub_r <= tx_sub_r + 4'd1;
				if (tx_sub_r == 4'hF) begin
					tx_sh_r <= {1'b1, tx_sh_r[10:1]};
					tx_out_r <= tx_sh_r[1];
					tx_bits_r <= tx_bits_r + 4'd1;
					if (tx_bits_r == tx_nbits - 4'd1) begin
						tx_busy_r <= 1'b0;
						tx_out_r <= 1'b1;
					end
				end
			end
		end
	end

	// Receiver: mode 0 shifts in on its tick; async modes oversample 16x.
	// The start bit is checked again at its middle so a glitch is dropped.
	// Busy clears at mid stop, which lets the next start bit be caught in time.
	logic [8:0] rx_sh_r;
	logic [3:0] rx_bits_r, rx_sub_r;
	logic rx_busy_r, rx_m0_r;
	logic [3:0] rx_nbits;
	logic rx_mid, rx_end, rx_keep;
	logic [7:0] rx_byte;
	assign rx_nbits = (mode == FMSP_MODE_UART8) ? 4'd9 : 4'd10;
	assign rx_mid = rx_tick16 && rx_sub_r == 4'd7;
	assign rx_end = rx_busy_r && ((rx_m0_r && m0_tick && rx_bits_r == 4'd7) ||
		(!rx_m0_r && rx_mid && rx_bits_r == rx_nbits)); // R19
	// Mode 0 byte assembles in the top bits; async bytes shift LSB first.
	assign rx_byte = rx_m0_r ? {rx_s2_r, rx_sh_r[8:2]} :
		((mode == FMSP_MODE_UART8) ? rx_sh_r[8:1] : rx_sh_r[7:0]);
	// Filtering: ninth bit must be one (modes 2,3) or stop valid (mode 1).
	assign rx9_set_val = rx_m0_r ? ctrl_r[FMSP_BIT_RX9] :
		(mode == FMSP_MODE_UART8) ? rx_s2_r : rx_sh_r[8]; // R5 R6
	// Mode 0 frames are never filtered, whatever the filter bit holds.
	assign rx_keep = rx_m0_r || !ctrl_r[FMSP_BIT_MPF] || rx9_set_val; // R13 R15 R16
	// Overrun: a byte completing while the flag is still set is dropped.
	// The receiver itself keeps running, so the next frame is not missed.
	assign rx_done_set = rx_end && rx_keep && !ctrl_r[FMSP_BIT_RXDONE]; // R25
	assign rx9_set = rx_done_set && !rx_m0_r;
	// Divider restart: a mode 0 data write, or the cycle that mode 0 reception begins.
	// Reception starts under the same guard as in the receiver below.
	assign m0_restart = mode == FMSP_MODE_SHIFT && (wr_data || (ctrl_r[FMSP_BIT_RXEN]
		&& !ctrl_r[FMSP_BIT_RXDONE] && !tx_busy_r && !rx_busy_r)); // R4 R11
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sh_r <= 9'h000;
			rx_bits_r <= 4'h0;
			rx_sub_r <= 4'h0;
			rx_busy_r <= 1'b0;
			rx_m0_r <= 1'b0;
		end else if (!rx_busy_r) begin
			rx_bits_r <= 4'h0;
			rx_sub_r <= 4'h0;
			if (mode == FMSP_MODE_SHIFT && ctrl_r[FMSP_BIT_RXEN] && !ctrl_r[FMSP_BIT_RXDONE]
				&& !tx_busy_r) begin // R11
				rx_busy_r <= 1'b1;
				rx_m0_r <= 1'b1;
			end else if (mode != FMSP_MODE_SHIFT && ctrl_r[FMSP_BIT_RXEN] && !rx_s2_r) begin
				rx_busy_r <= 1'b1; // R12
				rx_m0_r <= 1'b0;
			end
		end else if (rx_m0_r) begin
			if (m0_tick) begin
				rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]}; // R4
				rx_bits_r <= rx_bits_r + 4'd1;
				if (rx_bits_r == 4'd7)
					rx_busy_r <= 1'b0;
			end
		end else if (rx_tick16) begin
			rx_sub_r <= rx_sub_r + 4'd1;
			if (rx_sub_r == 4'd7) begin
				rx_bits_r <= rx_bits_r + 4'd1;
				if (rx_bits_r == 4'd0 && rx_s2_r)
					rx_busy_r <= 1'b0; // False start, drop it.
				else if (rx_bits_r == rx_nbits)
					rx_busy_r <= 1'b0; // Free again at mid stop, R2.
				else if (rx_bits_r != 4'd0)
					rx_sh_r <= {rx_s2_r, rx_sh_r[8:1]};
			end
		end
	end

	// Receive holding register; only updated when the done flag is clear.
	// Keeping the older byte on overrun means software never sees a half-read pair.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_hold_r <= 8'h00;
		else if (rx_done_set)
			rx_hold_r <= rx_byte; // R2 R25
	end

	// Control/status register; hardware sets win over software clears.
	// Clearing a flag by writing 0 loses nothing: a set in the same cycle wins.
	// A write also lands in the received ninth bit; the next accepted frame outside mode 0 overwrites it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= FMSP_CTRL_RST;
		else begin
			if (wr_ctrl)
				ctrl_r <= req.wdata[7:0]; // R17
			if (tx_done_set)
				ctrl_r[FMSP_BIT_TXDONE] <= 1'b1; // R24
			if (rx_done_set)
				ctrl_r[FMSP_BIT_RXDONE] <= 1'b1; // R24
			if (rx9_set)
				ctrl_r[FMSP_BIT_RX9] <= rx9_set_val;
		end
	end

	// Auxiliary rate/source register.
	// Upper bits of the word are ignored; busy bits read back but cannot be written.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			aux_r <= FMSP_AUX_RST;
		else if (wr_aux)
			aux_r <= req.wdata[2:0]; // R20 R22
	end

	// Read mux: data address returns the receive register, never tx data.
	// Reads have no side effect, so a polling loop never loses a flag.
	always_comb begin
		prdata = 32'h0000_0000;
		if (acc && !req.write) begin
			if (req.addr == FMSP_OFF_CTRL)
				prdata[7:0] = ctrl_r;
			else if (req.addr == FMSP_OFF_DATA)
				prdata[7:0] = rx_hold_r; // R3
			else if (req.addr == FMSP_OFF_AUX)
				prdata[4:0] = {rx_busy_r, tx_busy_r, aux_r};
		end
	end

	// Pin drive: in mode 0 the data pin is two-way and the aux pin is shift clock.
	// The shift clock is registered so it cannot glitch; it lags the divider by
	// one cycle, which keeps data steady around its falling edge.
	// In modes 1 to 3 the aux pin parks high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tx_sclk_r <= 1'b1;
		else
			tx_sclk_r <= !((tx_busy_r || (rx_busy_r && rx_m0_r)) && mode == FMSP_MODE_SHIFT
				&& m0_cnt_r >= 4'd4 && m0_cnt_r < 4'd10);
	end
	assign serial_data_oe = (mode != FMSP_MODE_SHIFT) || tx_busy_r; // R1
	assign serial_data_out = tx_out_r;
	assign serial_aux_out = (mode == FMSP_MODE_SHIFT) ? tx_sclk_r : 1'b1;

	AST_TX_NOT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_data |=> tx_busy_r) else $error("Data write did not start transmit"); // R10
	AST_RX_HOLD_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_r[FMSP_BIT_RXDONE] && !wr_ctrl |=> $stable(rx_hold_r))
		else $error("Held byte overwritten"); // R25
	AST_FLAG_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
		tx_done_set |=> ctrl_r[FMSP_BIT_TXDONE]) else $error("Tx done lost"); // R24
	AST_RX_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
		rx_done_set |=> ctrl_r[FMSP_BIT_RXDONE]) else $error("Rx done lost"); // R19
	AST_MP_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
		rx_done_set && ctrl_r[FMSP_BIT_MPF] && mode[1] |-> rx_sh_r[8])
		else $error("Filtered frame raised done"); // R13
	AST_READ_RX: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !req.write && req.addr == FMSP_OFF_DATA |-> prdata[7:0] == rx_hold_r)
		else $error("Data read not from receive register"); // R3
	AST_M0_TICK: assert property (@(posedge pclk) disable iff (!presetn)
		m0_tick |=> !m0_tick [*8]) else $error("Mode 0 tick too fast"); // R4
	AST_M2_DIV: assert property (@(posedge pclk) disable iff (!presetn)
		m2_tick && !aux_r[FMSP_BIT_DOUBLER] && !wr_aux |=> !m2_tick [*3])
		else $error("Mode 2 rate wrong"); // R20

	// Reception only ever begins under the enable conditions of its mode.
	// These look one cycle back because the busy bit rises after the guard.
	AST_M0_RX_GATE: assert property (@(posedge pclk) disable iff (!presetn) // R11
		$rose(rx_busy_r) && rx_m0_r |->
		$past(ctrl_r[FMSP_BIT_RXEN]) && !$past(ctrl_r[FMSP_BIT_RXDONE]))
		else $error("Mode 0 reception began while not allowed");
	AST_ASYNC_RX_GATE: assert property (@(posedge pclk) disable iff (!presetn) // R12
		$rose(rx_busy_r) && !rx_m0_r |-> $past(ctrl_r[FMSP_BIT_RXEN]))
		else $error("Frame reception began while disabled");
	AST_TX_DONE_HELD: assert property (@(posedge pclk) disable iff (!presetn) // R24
		ctrl_r[FMSP_BIT_TXDONE] && !wr_ctrl |=> ctrl_r[FMSP_BIT_TXDONE])
		else $error("Hardware cleared the transmit done flag");
	AST_RX_DONE_HELD: assert property (@(posedge pclk) disable iff (!presetn) // R24
		ctrl_r[FMSP_BIT_RXDONE] && !wr_ctrl |=> ctrl_r[FMSP_BIT_RXDONE])
		else $error("Hardware cleared the receive done flag");

	// Line and pin levels, frame contents and the stop-bit filter.
	AST_TX_LINE_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // R5
		!tx_busy_r |-> serial_data_out)
		else $error("Idle transmit line not at mark");
	AST_SCLK_PARKED: assert property (@(posedge pclk) disable iff (!presetn) // R4
		mode != FMSP_MODE_SHIFT |-> serial_aux_out)
		else $error("Shift clock active outside mode 0");
	AST_TX_NINTH: assert property (@(posedge pclk) disable iff (!presetn) // R7
		wr_data && mode[1] |=> tx_sh_r[9] == $past(ctrl_r[FMSP_BIT_TX9]))
		else $error("Ninth bit not taken from software field");
	AST_RX9_STOP: assert property (@(posedge pclk) disable iff (!presetn) // R5
		rx9_set && mode == FMSP_MODE_UART8 |=> ctrl_r[FMSP_BIT_RX9] == $past(rx_s2_r))
		else $error("Stop bit not stored in ninth field");
	AST_STOP_FILTER: assert property (@(posedge pclk) disable iff (!presetn) // R15
		rx_done_set && ctrl_r[FMSP_BIT_MPF] && mode == FMSP_MODE_UART8 |-> rx_s2_r)
		else $error("Frame with bad stop raised done");
endmodule // fmsp_serial_port
`default_nettype wire

/* File: fmsp_partner.sv */
/* Far-side serial node: sends frames on line_out, captures frames from line_in.
 * Assumes the bench gives bit periods in pclk cycles. */
`timescale 1ns/1ps
`default_nettype none
module fmsp_partner (
	input wire logic pclk,
	input wire logic line_in,
	input wire logic sclk_in,
	output logic line_out
);
	// The line idles at the mark level, as a pulled-up wire does.
	initial begin
		line_out = 1'b1;
	end
	// Start bit, nbits of d least significant first, then a stop bit.
	task automatic send(input logic [8:0] d, input int nbits, input int per);
		for (int i = -1; i <= nbits; i++) begin
			@(posedge pclk);
			line_out <= (i < 0) ? 1'b0 : (i == nbits) ? 1'b1 : d[i];
			repeat (per - 1) @(posedge pclk);
		end
	endtask
	// Samples mid-bit; d[nbits] holds the stop bit. A missing frame leaves d unknown.
	task automatic recv(input int nbits, input int per, output logic [9:0] d);
		int n;
		d = 'x;
		n = 0;
		while (line_in !== 1'b0 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000) return;
		d = '0;
		repeat (per / 2) @(posedge pclk);
		for (int i = 0; i <= nbits; i++) begin
			repeat (per) @(posedge pclk);
			d[i] = line_in;
		end
	endtask
	// Shift-register capture on falling shift-clock edges; gap is the last clock period.
	task automatic recv_sync(output logic [7:0] d, output int gap);
		int n;
		d = 'x;
		gap = 0;
		for (int i = 0; i < 8; i++) begin
			n = 0;
			while (sclk_in !== 1'b1 && n < 5000) begin
				@(posedge pclk);
				n++;
			end
			while (sclk_in !== 1'b0 && n < 5000) begin
				@(posedge pclk);
				n++;
			end
			if (n >= 5000) return;
			d[i] = line_in;
			gap = n;
		end
	endtask
	// Mode 0 source: each bit is held from one rising shift-clock edge to the next,
	// so the port samples it well clear of any change.
	task automatic drive_sync(input logic [7:0] d);
		int n;
		n = 0;
		for (int i = 0; i < 8; i++) begin
			line_out <= d[i];
			while (sclk_in !== 1'b0 && n < 5000) begin
				@(posedge pclk);
				n++;
			end
			while (sclk_in !== 1'b1 && n < 5000) begin
				@(posedge pclk);
				n++;
			end
		end
		line_out <= 1'b1;
	endtask
endmodule // fmsp_partner
`default_nettype wire

/* File: fmsp_serial_port_tb.sv */
/* Self-checking bench for the serial port: APB master, timer pulses, far-side node.
 * Assumes zero-wait APB and the register map of the package. */
`timescale 1ns/1ps
`default_nettype none
module fmsp_serial_port_tb;
	import fmsp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, timer1_ovf, timer2_ovf;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, serial_data_out, serial_data_oe, serial_aux_out, pt_line;
	int n_mismatch = 0;
	int comparisons = 0;
	fmsp_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
		.serial_data_in(pt_line), .serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe), .serial_aux_out(serial_aux_out));
	fmsp_partner partner (.pclk(pclk), .line_in(serial_data_out), .sclk_in(serial_aux_out),
		.line_out(pt_line));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Both timers overflow every second cycle, so each rate source has a known bit period.
	always @(posedge pclk) begin
		timer1_ovf <= ~timer1_ovf;
		timer2_ovf <= ~timer2_ovf;
	end
	task automatic complete_run();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) begin
			n_mismatch++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp);
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rdchk(FMSP_OFF_CTRL, 32'h0);
		rdchk(FMSP_OFF_AUX, 32'h0);
		apb(1'b0, 8'h0C, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		check(r, 32'h0);
	endtask
	// Fixed-rate nine-bit frame; the ninth bit comes from the control field.
	task automatic t_mode2(input logic dbl, input logic [7:0] d, input logic n9);
		logic [9:0] f;
		wr(FMSP_OFF_AUX, {7'h0, dbl});
		wr(FMSP_OFF_CTRL, {4'h8, n9, 3'h0});
		fork
			wr(FMSP_OFF_DATA, d);
			partner.recv(9, dbl ? 32 : 64, f);
		join
		check({22'h0, f}, {22'h0, 1'b1, n9, d});
		rdchk(FMSP_OFF_CTRL, {24'h0, 4'h8, n9, 3'h2});
		rdchk(FMSP_OFF_DATA, 32'h0);
		wr(FMSP_OFF_CTRL, 8'h80);
		rdchk(FMSP_OFF_CTRL, 32'h80);
	endtask
	// Transmit on the timer 1 rate while receiving on the timer 2 rate.
	task automatic t_duplex();
		logic [9:0] f;
		wr(FMSP_OFF_AUX, 8'h04);
		wr(FMSP_OFF_CTRL, 8'h50);
		fork
			begin
				wr(FMSP_OFF_DATA, 8'h5A);
				partner.recv(8, 64, f);
			end
			partner.send(9'h03C, 8, 32);
		join
		check({22'h0, f}, 32'h15A);
		repeat (40) @(posedge pclk);
		rdchk(FMSP_OFF_CTRL, 32'h57);
		rdchk(FMSP_OFF_DATA, 32'h3C);
		partner.send(9'h0C3, 8, 32);
		repeat (40) @(posedge pclk);
		rdchk(FMSP_OFF_DATA, 32'h3C);
		rdchk(FMSP_OFF_CTRL, 32'h57);
	endtask
	// With the filter on, only a frame whose ninth bit is set raises the done flag.
	task automatic t_multi();
		wr(FMSP_OFF_AUX, 8'h00);
		wr(FMSP_OFF_CTRL, 8'hF0);
		partner.send(9'h0AB, 9, 64);
		repeat (40) @(posedge pclk);
		rdchk(FMSP_OFF_CTRL, 32'hF0);
		rdchk(FMSP_OFF_DATA, 32'h3C);
		partner.send(9'h1A7, 9, 64);
		repeat (40) @(posedge pclk);
		rdchk(FMSP_OFF_CTRL, 32'hF5);
		rdchk(FMSP_OFF_DATA, 32'hA7);
	endtask
	task automatic t_mode0();
		logic [7:0] b;
		int g;
		wr(FMSP_OFF_CTRL, 8'h00);
		fork
			wr(FMSP_OFF_DATA, 8'h96);
			partner.recv_sync(b, g);
		join
		check({24'h0, b}, 32'h96);
		check(g, 32'd12);
		repeat (20) @(posedge pclk);
		rdchk(FMSP_OFF_CTRL, 32'h02);
	endtask
	// Mode 0 receive starts on enable with done clear; the filter bit has no effect.
	task automatic t_m0_rx();
		wr(FMSP_OFF_CTRL, 8'h30);
		partner.drive_sync(8'h69);
		repeat (20) @(posedge pclk);
		rdchk(FMSP_OFF_DATA, 32'h69);
		rdchk(FMSP_OFF_CTRL, 32'h31);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		timer1_ovf = 1'b0;
		timer2_ovf = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mode2(1'b0, 8'hA5, 1'b1);
		t_mode2(1'b1, 8'h3E, 1'b0);
		t_duplex();
		t_multi();
		t_mode0();
		t_m0_rx();
		complete_run();
	end
	// A hang anywhere is cut short and counted.
	initial begin
		repeat (90000) @(posedge pclk);
		n_mismatch++;
		complete_run();
	end
endmodule // fmsp_serial_port_tb
`default_nettype wire
